// File: crs_pkg.sv
// constants and carrier types of the card reader status and control block
package crs_pkg;
   // register indices; byte address is four times the index
   localparam logic [3:0] IDX_CSR = 4'h0;
   localparam logic [3:0] IDX_TOC = 4'h8;
   localparam logic [3:0] IDX_TIMEOUT_COUNT_LOW = 4'h9;
   localparam logic [3:0] IDX_TIMEOUT_COUNT_MID = 4'ha;
   localparam logic [3:0] IDX_TIMEOUT_COUNT_HIGH = 4'hb;
   localparam logic [3:0] IDX_FCR = 4'hc;
   localparam logic [3:0] IDX_MSR = 4'hd;
   localparam logic [3:0] IDX_USR = 4'he;
   localparam logic [3:0] IDX_HSR = 4'hf;
   // card select fields
   localparam int CSR_UART_RST_BIT = 3;
   localparam logic [7:0] CSR_USED_MASK = 8'h08;
   localparam logic [7:0] CSR_RST = 8'h00;
   // hardware event status fields
   localparam int HSR_SHUTDOWN_REQUEST_FLAG_BIT = 7;
   localparam int HSR_PROT_BIT = 5;
   localparam int HSR_SUPERVISOR_LATCH_BIT = 4;
   localparam int HSR_PRES_BIT = 2;
   localparam int HSR_HEAT_BIT = 0;
   localparam logic [7:0] HSR_USED_MASK = 8'hb5;
   localparam logic [7:0] HSR_IRQ_MASK = 8'ha5;
   localparam logic [7:0] HSR_EMERG_MASK = 8'h35;
   localparam logic [7:0] HSR_RST = 8'h00;
   // uart status fields
   localparam int USR_FLAG_BIT = 0;
   localparam int USR_TMAIN_BIT = 1;
   localparam int USR_TAUX_BIT = 2;
   // mixed status fields
   localparam int MSR_PRES_BIT = 0;
   localparam int MSR_FLAG_BIT = 1;
   // fifo control fields
   localparam int FCR_DEPTH_LSB = 0;
   localparam int FCR_RETX_BIT = 3;
   localparam int FCR_FLAG_MASK_BIT = 7;
   localparam logic [7:0] FCR_RST = 8'h00;
   // time-out configuration fields
   localparam int TOC_MAIN_LSB = 0;
   localparam int TOC_AUX_LSB = 2;
   localparam int TOC_SPLIT_BIT = 4;
   localparam logic [7:0] TOC_RST = 8'h00;
   localparam logic [7:0] TOR_RST = 8'h00;
   // least time the uart reset bit stays low before activation
   localparam int UART_RST_MIN_NS = 10;
   localparam int CLK_PERIOD_NS = 8;
   localparam int UART_RST_MIN_CYC = (UART_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // time-out counter start modes
   localparam logic [1:0] TMODE_OFF = 2'h0;
   localparam logic [1:0] TMODE_WRITE = 2'h1;
   localparam logic [1:0] TMODE_STARTBIT = 2'h2;
   localparam logic [1:0] TMODE_RELOAD = 2'h3;
   typedef enum logic [1:0] {TMR_IDLE, TMR_WAIT_START, TMR_RUN} crs_tmr_state_t;
   // fault sources from the analog card interface
   typedef struct packed {
      logic vcc_fault;
      logic rst_fault;
      logic overheat;
      logic supply_dropout;
   } crs_faults_t;
   // settings handed to the iso uart
   typedef struct packed {
      logic uart_reset_n;
      logic [2:0] fifo_depth_m1;
      logic auto_retransmit;
   } crs_uart_cfg_t;
endpackage

// File: crs_status_control.sv
// card reader general control and status registers on an ahb-lite slave
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module crs_status_control (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // event sources
   input wire logic shutdown_request_pin_n,
   input wire crs_pkg::crs_faults_t faults,
   input wire logic por_pulse,
   input wire logic card_presence_bit,
   input wire logic tx_empty_rx_full_flag,
   input wire logic etu_tick,
   input wire logic io_start_bit,
   // results
   output logic interrupt_out_n,
   output logic activation_stop,
   output crs_pkg::crs_uart_cfg_t uart_cfg
);

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   function automatic logic reg_hit(input logic [31:0] a, input logic [3:0] idx);
      reg_hit = (a[31:6] == 26'h0) && (a[5:2] == idx);
   endfunction

   logic acc;
   logic rd_acc;
   logic hsr_rd_acc;
   logic usr_rd_acc;
   logic wr_pend_q;
   logic [31:0] wr_addr_q;
   logic [31:0] rdata_d;
   logic [31:0] hrdata_q;
   logic [7:0] csr_q;
   logic [7:0] toc_q;
   logic [7:0] fcr_q;
   logic [7:0] usr_q;
   logic [7:0] usr_d;
   logic [7:0] hsr_q;
   logic [7:0] hsr_set;
   logic [7:0] clr_q;
   logic [7:0] mixed_status_reg;
   logic [7:0] tor_q [3];
   logic pin_q;
   logic pres_q;
   logic pres_vld_q;
   logic flag_q;
   logic irq_n_q;
   logic stop_q;
   logic toc_arm_q;
   logic uart_rst_n;
   logic [1:0] tmode [2];
   logic [23:0] tload [2];
   logic [23:0] tcnt_q [2];
   logic texp [2];
   crs_pkg::crs_tmr_state_t tst_q [2];

   // zero wait state, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;
   assign acc = hsel && htrans[1] && hready;
   assign rd_acc = acc && !hwrite;
   assign hsr_rd_acc = rd_acc && reg_hit(haddr, crs_pkg::IDX_HSR);
   assign usr_rd_acc = rd_acc && reg_hit(haddr, crs_pkg::IDX_USR);
   assign uart_rst_n = csr_q[crs_pkg::CSR_UART_RST_BIT];

   // write address held into the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 32'h0;
      end else begin
         wr_pend_q <= acc && hwrite;
         if (acc) begin
            wr_addr_q <= haddr;
         end
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   // mixed status is polled only and feeds no interrupt
   always_comb begin
      mixed_status_reg = 8'h00;
      mixed_status_reg[crs_pkg::MSR_PRES_BIT] = card_presence_bit;
      mixed_status_reg[crs_pkg::MSR_FLAG_BIT] = tx_empty_rx_full_flag;
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rdata_d = 32'h0;
      if (haddr[31:6] == 26'h0) begin
         case (haddr[5:2])
            crs_pkg::IDX_CSR: rdata_d[7:0] = csr_q & crs_pkg::CSR_USED_MASK;
            crs_pkg::IDX_TOC: rdata_d[7:0] = toc_q;
            crs_pkg::IDX_TIMEOUT_COUNT_LOW: rdata_d[7:0] = tor_q[0];
            crs_pkg::IDX_TIMEOUT_COUNT_MID: rdata_d[7:0] = tor_q[1];
            crs_pkg::IDX_TIMEOUT_COUNT_HIGH: rdata_d[7:0] = tor_q[2];
            crs_pkg::IDX_FCR: rdata_d[7:0] = fcr_q;
            crs_pkg::IDX_MSR: rdata_d[7:0] = mixed_status_reg;
            crs_pkg::IDX_USR: rdata_d[7:0] = usr_q;
            crs_pkg::IDX_HSR: rdata_d[7:0] = hsr_q & crs_pkg::HSR_USED_MASK;
            default: rdata_d = 32'h0;
         endcase
      end
   end

   // read data captured in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0;
      end else if (rd_acc) begin
         hrdata_q <= rdata_d;
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   // card select: only the uart reset bit is kept
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         csr_q <= crs_pkg::CSR_RST;
      end else if (wr_pend_q && reg_hit(wr_addr_q, crs_pkg::IDX_CSR)) begin
         csr_q <= hwdata[7:0] & crs_pkg::CSR_USED_MASK;
      end
   end

   // fifo control, held at its initial value during uart reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fcr_q <= crs_pkg::FCR_RST;
      end else if (!uart_rst_n) begin
         fcr_q <= crs_pkg::FCR_RST;
      end else if (wr_pend_q && reg_hit(wr_addr_q, crs_pkg::IDX_FCR)) begin
         fcr_q <= hwdata[7:0];
      end
   end

   // uart settings out
   always_comb begin
      uart_cfg.uart_reset_n = uart_rst_n;
      uart_cfg.fifo_depth_m1 = fcr_q[crs_pkg::FCR_DEPTH_LSB +: 3];
      uart_cfg.auto_retransmit = fcr_q[crs_pkg::FCR_RETX_BIT];
   end

   // time-out configuration; a write arms the counters a cycle later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         toc_q <= crs_pkg::TOC_RST;
         toc_arm_q <= 1'b0;
      end else begin
         toc_arm_q <= wr_pend_q && reg_hit(wr_addr_q, crs_pkg::IDX_TOC);
         if (wr_pend_q && reg_hit(wr_addr_q, crs_pkg::IDX_TOC)) begin
            toc_q <= hwdata[7:0];
         end
      end
   end

   // time-out reload values, low, mid and high bytes
   for (genvar g = 0; g < 3; g++) begin : g_tor
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            tor_q[g] <= crs_pkg::TOR_RST;
         end else if (wr_pend_q && reg_hit(wr_addr_q, crs_pkg::IDX_TIMEOUT_COUNT_LOW + 4'(g))) begin
            tor_q[g] <= hwdata[7:0];
         end
      end
   end

   // ----------------------------------------
   // time-out counters
   // ----------------------------------------
   // counter 0 is 24-bit, or 16-bit when split; counter 1 is 8-bit, split only
   always_comb begin
      tmode[0] = toc_q[crs_pkg::TOC_MAIN_LSB +: 2];
      tmode[1] = toc_q[crs_pkg::TOC_SPLIT_BIT] ? toc_q[crs_pkg::TOC_AUX_LSB +: 2]
                                                : crs_pkg::TMODE_OFF;
      tload[0] = toc_q[crs_pkg::TOC_SPLIT_BIT] ? {8'h00, tor_q[2], tor_q[1]}
                                                : {tor_q[2], tor_q[1], tor_q[0]};
      tload[1] = {16'h0000, tor_q[0]};
   end

   for (genvar g = 0; g < 2; g++) begin : g_tmr
      // expiry on the tick that brings the count to its end
      assign texp[g] = (tst_q[g] == crs_pkg::TMR_RUN) && etu_tick && (tcnt_q[g] <= 24'h000001);

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            tst_q[g] <= crs_pkg::TMR_IDLE;
            tcnt_q[g] <= 24'h0;
         end else if (toc_arm_q) begin
            case (tmode[g])
               crs_pkg::TMODE_WRITE, crs_pkg::TMODE_RELOAD: begin
                  tst_q[g] <= crs_pkg::TMR_RUN;
                  tcnt_q[g] <= tload[g];
               end
               crs_pkg::TMODE_STARTBIT: begin
                  tst_q[g] <= crs_pkg::TMR_WAIT_START;
               end
               default: begin
                  tst_q[g] <= crs_pkg::TMR_IDLE;
               end
            endcase
         end else begin
            case (tst_q[g])
               crs_pkg::TMR_WAIT_START: begin
                  if (io_start_bit) begin
                     tst_q[g] <= crs_pkg::TMR_RUN;
                     tcnt_q[g] <= tload[g];
                  end
               end
               crs_pkg::TMR_RUN: begin
                  if (texp[g]) begin
                     if (tmode[g] == crs_pkg::TMODE_RELOAD) begin
                        tcnt_q[g] <= tload[g];
                     end else begin
                        tst_q[g] <= crs_pkg::TMR_IDLE;
                     end
                  end else if (etu_tick) begin
                     tcnt_q[g] <= tcnt_q[g] - 24'h000001;
                  end
               end
               default: begin
                  tst_q[g] <= crs_pkg::TMR_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // uart status
   // ----------------------------------------
   // sticky events, cleared by a read; a new event wins over the clear
   always_comb begin
      usr_d = usr_rd_acc ? 8'h00 : usr_q;
      usr_d[crs_pkg::USR_FLAG_BIT] = usr_d[crs_pkg::USR_FLAG_BIT] | (tx_empty_rx_full_flag
                                                                    & !flag_q);
      usr_d[crs_pkg::USR_TMAIN_BIT] = usr_d[crs_pkg::USR_TMAIN_BIT] | texp[0];
      usr_d[crs_pkg::USR_TAUX_BIT] = usr_d[crs_pkg::USR_TAUX_BIT] | texp[1];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         usr_q <= 8'h00;
         flag_q <= 1'b0;
      end else begin
         flag_q <= tx_empty_rx_full_flag;
         usr_q <= uart_rst_n ? usr_d : 8'h00;
      end
   end

   // ----------------------------------------
   // hardware event status
   // ----------------------------------------
   // set sources of the latches
   always_comb begin
      hsr_set = 8'h00;
      hsr_set[crs_pkg::HSR_SHUTDOWN_REQUEST_FLAG_BIT] = !shutdown_request_pin_n;
      hsr_set[crs_pkg::HSR_PROT_BIT] = faults.vcc_fault | faults.rst_fault;
      hsr_set[crs_pkg::HSR_SUPERVISOR_LATCH_BIT] = por_pulse | faults.supply_dropout
                                       | (shutdown_request_pin_n & !pin_q);
      hsr_set[crs_pkg::HSR_PRES_BIT] = pres_vld_q && (card_presence_bit != pres_q);
      hsr_set[crs_pkg::HSR_HEAT_BIT] = faults.overheat;
   end

   // clear mask taken at the read, applied one edge later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clr_q <= 8'h00;
      end else if (hsr_rd_acc) begin
         clr_q <= hsr_q & crs_pkg::HSR_USED_MASK;
         clr_q[crs_pkg::HSR_SHUTDOWN_REQUEST_FLAG_BIT] <= hsr_q[crs_pkg::HSR_SHUTDOWN_REQUEST_FLAG_BIT]
                                         & shutdown_request_pin_n;
         clr_q[crs_pkg::HSR_SUPERVISOR_LATCH_BIT] <= hsr_q[crs_pkg::HSR_SUPERVISOR_LATCH_BIT] & !por_pulse;
      end else begin
         clr_q <= 8'h00;
      end
   end

   // latches; a set in the clearing cycle wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hsr_q <= crs_pkg::HSR_RST;
         pin_q <= 1'b1;
         pres_q <= 1'b0;
         pres_vld_q <= 1'b0;
      end else begin
         hsr_q <= hsr_set | (hsr_q & ~clr_q);
         pin_q <= shutdown_request_pin_n;
         pres_q <= card_presence_bit;
         pres_vld_q <= 1'b1;
      end
   end

   // ----------------------------------------
   // interrupt and emergency stop
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_n_q <= 1'b1;
         stop_q <= 1'b0;
      end else begin
         irq_n_q <= !(|(hsr_q & crs_pkg::HSR_IRQ_MASK)
                      | (usr_q[crs_pkg::USR_FLAG_BIT] & !fcr_q[crs_pkg::FCR_FLAG_MASK_BIT])
                      | usr_q[crs_pkg::USR_TMAIN_BIT] | usr_q[crs_pkg::USR_TAUX_BIT]);
         stop_q <= |(hsr_set & crs_pkg::HSR_EMERG_MASK);
      end
   end

   assign interrupt_out_n = irq_n_q;
   assign activation_stop = stop_q;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_prot_read;
      hsr_rd_acc && hsr_q[crs_pkg::HSR_PROT_BIT];
   endsequence

   sequence s_prot_quiet;
      !(faults.vcc_fault || faults.rst_fault);
   endsequence

   a_uart_held_reset: assert property (!uart_rst_n |=> fcr_q == crs_pkg::FCR_RST && usr_q == 8'h00)
      else $error("uart registers not held during uart reset");
   a_irq_from_hsr: assert property (|(hsr_q & crs_pkg::HSR_IRQ_MASK) |=> !interrupt_out_n)
      else $error("interrupt not driven for status bit");
   a_clear_not_early: assert property (s_prot_read |=> hsr_q[crs_pkg::HSR_PROT_BIT])
      else $error("status bit cleared too early");
   a_clear_two_cycles: assert property (s_prot_read ##1 s_prot_quiet |=> !hsr_q[crs_pkg::HSR_PROT_BIT])
      else $error("status bit not cleared two cycles after read");
   a_stop_on_emergency: assert property ($rose(hsr_q[crs_pkg::HSR_PROT_BIT]) |-> activation_stop)
      else $error("activation not stopped on protection event");
   a_status_unused_zero: assert property (hsr_rd_acc |=> (hrdata[7:0] & 8'h4a) == 8'h00)
      else $error("unused status bits read nonzero");
   a_shutdown_sets: assert property (!shutdown_request_pin_n |=> hsr_q[crs_pkg::HSR_SHUTDOWN_REQUEST_FLAG_BIT])
      else $error("shut-down bit not set by pin");
   a_shutdown_stays: assert property ($fell(hsr_q[crs_pkg::HSR_SHUTDOWN_REQUEST_FLAG_BIT]) |-> $past(shutdown_request_pin_n))
      else $error("shut-down left with pin low");
   a_flag_masked: assert property (fcr_q[crs_pkg::FCR_FLAG_MASK_BIT] && (usr_q[2:1] == 2'b00)
                                   && ((hsr_q & crs_pkg::HSR_IRQ_MASK) == 8'h00) |=> interrupt_out_n)
      else $error("masked flag raised interrupt");
   a_timeout_event: assert property (texp[0] && uart_rst_n |=> usr_q[crs_pkg::USR_TMAIN_BIT])
      else $error("time-out expiry not flagged");
   a_csr_only_bit3: assert property (rd_acc && reg_hit(haddr, crs_pkg::IDX_CSR) |=> (hrdata & 32'hfffffff7) == 32'h0)
      else $error("card select unused bits nonzero");
   a_prot_latch_set: assert property (faults.vcc_fault || faults.rst_fault |=> hsr_q[crs_pkg::HSR_PROT_BIT])
      else $error("protection latch not set");
   a_presence_change: assert property (pres_vld_q && card_presence_bit != pres_q |=> hsr_q[crs_pkg::HSR_PRES_BIT])
      else $error("presence change not latched");
   a_supervisor_latch_por: assert property (por_pulse |=> hsr_q[crs_pkg::HSR_SUPERVISOR_LATCH_BIT])
      else $error("supervisor latch not set at por");

endmodule
`default_nettype wire

// File: crs_ctrl_model.sv
// controller-side model: ahb-lite master and software habits
`timescale 1ns/1ns
`default_nettype none
module crs_ctrl_model (
   // clock
   input wire logic hclk,
   // ahb-lite master
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   // idle bus at time zero
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // address phase, held until hready is seen high
   task automatic addr_phase(input logic [3:0] idx, input logic wr);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {26'h0, idx, 2'h0};
      hwrite <= wr;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
   endtask
   // single word write
   task automatic bus_write(input logic [3:0] idx, input logic [7:0] d);
      addr_phase(idx, 1'b1);
      hwdata <= {24'h0, d};
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      hwdata <= ~hwdata; // released data must not keep showing the last value
   endtask
   // single word read, data taken at the data phase edge
   task automatic bus_read(input logic [3:0] idx, output logic [31:0] d);
      addr_phase(idx, 1'b0);
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      d = hrdata;
   endtask
   // uart bring-up: reset bit low for the minimum time, then released
   task automatic uart_enable();
      bus_write(crs_pkg::IDX_CSR, 8'h00);
      repeat (crs_pkg::UART_RST_MIN_CYC) @(posedge hclk);
      bus_write(crs_pkg::IDX_CSR, 8'h08);
   endtask
   // shut-down reaction: uart parked in reset, card left idle
   task automatic shutdown_react();
      bus_write(crs_pkg::IDX_CSR, 8'h00);
   endtask
endmodule
`default_nettype wire

// File: card_reader_status_control_test.sv
// self-checking testbench of the card reader status and control block
`timescale 1ns/1ns
`default_nettype none
module card_reader_status_control_test;
   localparam logic [3:0] A_CSR = crs_pkg::IDX_CSR;
   localparam logic [3:0] A_HSR = crs_pkg::IDX_HSR;
   localparam logic [3:0] A_USR = crs_pkg::IDX_USR;
   localparam logic [3:0] A_MSR = crs_pkg::IDX_MSR;
   localparam logic [3:0] A_FCR = crs_pkg::IDX_FCR;
   localparam logic [3:0] A_TOC = crs_pkg::IDX_TOC;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, interrupt_out_n;
   logic shutdown_request_pin_n, por_pulse, card_presence_bit, tx_empty_rx_full_flag;
   logic etu_tick, io_start_bit, activation_stop;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   crs_pkg::crs_faults_t faults;
   crs_pkg::crs_uart_cfg_t uart_cfg;
   int fails = 0;
   int n_compared = 0;
   assign hready = hreadyout;
   crs_status_control uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .shutdown_request_pin_n(shutdown_request_pin_n), .faults(faults), .por_pulse(por_pulse),
      .card_presence_bit(card_presence_bit), .tx_empty_rx_full_flag(tx_empty_rx_full_flag),
      .etu_tick(etu_tick), .io_start_bit(io_start_bit), .interrupt_out_n(interrupt_out_n),
      .activation_stop(activation_stop), .uart_cfg(uart_cfg));
   crs_ctrl_model ctl (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
   // 125 MHz clock
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp, input string what);
      logic [31:0] d;
      ctl.bus_read(idx, d);
      chk(d, {24'h0, exp}, what);
   endtask
   // one etu pulse
   task automatic tick();
      etu_tick <= 1'b1;
      cyc(1);
      etu_tick <= 1'b0;
      cyc(1);
   endtask
   // load count 2, start per mode, expect expiry on the second counted tick
   task automatic timer_case(input logic [7:0] timeout_config_reg, input bit sb, input int reps,
                             input logic [7:0] uart_status_reg);
      ctl.bus_write(crs_pkg::IDX_TIMEOUT_COUNT_LOW, 8'h02);
      ctl.bus_write(A_TOC, timeout_config_reg);
      cyc(3);
      if (sb) begin
         tick();
         tick();
         io_start_bit <= 1'b1;
         cyc(1);
         io_start_bit <= 1'b0;
         cyc(2);
      end
      repeat (reps) begin
         tick();
         chk(interrupt_out_n, 1'b1, "early expiry");
         tick();
         cyc(3);
         chk(interrupt_out_n, 1'b0, "expiry irq");
         rd_chk(A_USR, uart_status_reg, "expiry flag");
         cyc(3);
      end
      ctl.bus_write(A_TOC, 8'h00);
   endtask
   task automatic stop_test();
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // fault sources, latched bit and interrupt expectation
   crs_pkg::crs_faults_t fsrc[4] = '{4'h8, 4'h4, 4'h2, 4'h1};
   logic [7:0] fexp[4] = '{8'h20, 8'h20, 8'h01, 8'h10};
   logic firq[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
   // main sequence
   initial begin
      {hresetn, etu_tick, io_start_bit, card_presence_bit, tx_empty_rx_full_flag} = '0;
      {shutdown_request_pin_n, por_pulse} = 2'h3;
      faults = '0;
      cyc(16);
      hresetn <= 1'b1;
      cyc(3);
      chk(uart_cfg, 5'h00, "uart cfg reset");
      chk(hresp, 1'b0, "bus response okay");
      chk(hreadyout, 1'b1, "bus ready");
      rd_chk(A_CSR, 8'h00, "csr reset");
      rd_chk(A_HSR, 8'h10, "por latch");
      por_pulse <= 1'b0;
      cyc(2);
      rd_chk(A_HSR, 8'h10, "latch held in por");
      cyc(3);
      rd_chk(A_HSR, 8'h00, "latch cleared");
      ctl.bus_write(A_CSR, 8'hf7);
      rd_chk(A_CSR, 8'h00, "csr unused bits");
      ctl.bus_write(A_HSR, 8'hff);
      rd_chk(A_HSR, 8'h00, "hsr read only");
      ctl.bus_write(4'h5, 8'hff);
      rd_chk(4'h5, 8'h00, "unmapped");
      $display("test registers done");
      for (int i = 0; i < 4; i++) begin
         faults <= fsrc[i];
         cyc(3);
         chk(activation_stop, 1'b1, "emergency stop");
         faults <= '0;
         cyc(3);
         chk(activation_stop, 1'b0, "stop released");
         chk(interrupt_out_n, firq[i], "fault irq");
         rd_chk(A_HSR, fexp[i], "fault latch");
         cyc(4);
         chk(interrupt_out_n, 1'b1, "irq cleared");
         rd_chk(A_HSR, 8'h00, "fault cleared");
      end
      card_presence_bit <= 1'b1;
      cyc(3);
      chk(interrupt_out_n, 1'b0, "presence irq");
      rd_chk(A_HSR, 8'h04, "presence latch");
      rd_chk(A_MSR, 8'h01, "presence live");
      $display("test faults done");
      shutdown_request_pin_n <= 1'b0;
      cyc(3);
      chk(interrupt_out_n, 1'b0, "shut-down irq");
      rd_chk(A_HSR, 8'h80, "shut-down bit");
      ctl.shutdown_react();
      cyc(3);
      rd_chk(A_HSR, 8'h80, "shut-down held");
      shutdown_request_pin_n <= 1'b1;
      cyc(3);
      rd_chk(A_HSR, 8'h90, "shut-down exit");
      cyc(3);
      rd_chk(A_HSR, 8'h00, "shut-down cleared");
      $display("test shut-down done");
      ctl.uart_enable();
      ctl.bus_write(A_FCR, 8'h8f);
      cyc(1);
      chk(uart_cfg, 5'h1f, "fifo cfg");
      tx_empty_rx_full_flag <= 1'b1;
      cyc(4);
      chk(interrupt_out_n, 1'b1, "masked flag");
      rd_chk(A_MSR, 8'h03, "mixed status");
      rd_chk(A_USR, 8'h01, "flag event");
      tx_empty_rx_full_flag <= 1'b0;
      ctl.bus_write(A_FCR, 8'h02);
      cyc(1);
      chk(uart_cfg, 5'h14, "fifo depth 3");
      tx_empty_rx_full_flag <= 1'b1;
      cyc(4);
      chk(interrupt_out_n, 1'b0, "flag irq");
      rd_chk(A_USR, 8'h01, "flag read");
      ctl.bus_write(A_CSR, 8'h00);
      cyc(2);
      chk(uart_cfg, 5'h00, "uart held");
      rd_chk(A_FCR, 8'h00, "fcr held");
      $display("test uart done");
      ctl.uart_enable();
      timer_case(8'h01, 1'b0, 1, 8'h02);
      timer_case(8'h14, 1'b0, 1, 8'h04);
      timer_case(8'h02, 1'b1, 1, 8'h02);
      timer_case(8'h03, 1'b0, 2, 8'h02);
      $display("test timer done");
      stop_test();
   end
   // watchdog
   initial begin
      #400000;
      fails++;
      stop_test();
   end
endmodule
`default_nettype wire
